//--- common/sleep_wakeup_defs.vh
// Constants for the sleep and wake-up controller
`ifndef SLEEP_WAKEUP_DEFS_VH
`define SLEEP_WAKEUP_DEFS_VH
`define ADDR_CTRL        6'h00
`define ADDR_STATUS      6'h04
`define ADDR_WDT_CTRL    6'h08
`define ADDR_INT_ENABLE  6'h0C
`define ADDR_INT_FLAG    6'h10
`define ADDR_WAKE_CAUSE  6'h14
`define CTRL_GIE_BIT     0
`define CTRL_ADC_RC_BIT  1
`define CTRL_OSC_LSB     2
`define CTRL_OSC_MSB     3
`define STAT_PD_BIT      3
`define STAT_TO_BIT      4
`define OSC_MODE_XT      2'h1
`define OSC_MODE_HS      2'h2
`define OSC_MODE_LP      2'h3
`define WDT_CTRL_RESET   6'h16
`define WDTE_ALWAYS      2'h3
`define WDTE_AWAKE       2'h2
`define WDTE_SOFT        2'h1
`define OST_PERIODS      1024
`define DUMMY_CYCLES     2
`define ISR_VECTOR       15'h0004
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

//--- logic/sleep_wakeup_controller.v
// Sleep entry, wake-up and resume sequencing for a small microcontroller core
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "sleep_wakeup_defs.vh"
module sleep_wakeup_controller #(
    parameter NUM_INTS  = 16,
    parameter WDT_WIDTH = 24,
    parameter LF_DIV    = 8064,
    parameter NUM_IO    = 8
) (
    input  wire                mclk_i,
    input  wire                reset_n_i,
    input  wire                sleep_exec_i,
    input  wire                clrwdt_exec_i,
    input  wire                instr_done_i,
    input  wire                por_i,
    input  wire                brownout_reset_i,
    input  wire                brownout_en_i,
    input  wire                master_clear_pin_i,
    input  wire                master_clear_en_i,
    input  wire [1:0]          wdt_mode_i,
    input  wire [NUM_INTS-1:0] int_src_i,
    input  wire [NUM_INTS-1:0] int_sleep_capable_i,
    input  wire [NUM_IO-1:0]   io_out_i,
    input  wire [NUM_IO-1:0]   io_oe_i,
    input  wire [5:0]          s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [5:0]          s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    output wire                cpu_clk_en_o,
    output wire                lf_osc_en_o,
    output wire                sec_osc_en_o,
    output wire                adc_clk_en_o,
    output wire                sense_osc_en_o,
    output reg                 device_reset_o,
    output reg                 prefetch_o,
    output reg                 vector_o,
    output reg  [14:0]         vector_addr_o,
    output reg                 dummy_cycle_o,
    output reg                 asleep_o,
    output reg  [NUM_IO-1:0]   io_out_o,
    output reg  [NUM_IO-1:0]   io_oe_o
);
    localparam ST_AWAKE = 5'b00001;
    localparam ST_SLEEP = 5'b00010;
    localparam ST_OST   = 5'b00100;
    localparam ST_NEXT  = 5'b01000;
    localparam ST_DUMMY = 5'b10000;

    // Last count of each counter; compares use these rather than lengths
    localparam integer LF_LAST    = LF_DIV - 1;
    localparam integer OST_LAST   = `OST_PERIODS - 1;
    localparam integer DUMMY_LAST = `DUMMY_CYCLES - 1;

    reg  [4:0]          state_q;
    reg  [4:0]          state_d;
    reg  [3:0]          ctrl_q;
    reg                 pd_flag_n_q;
    reg                 to_flag_n_q;
    reg  [5:0]          wdt_ctrl_q;
    reg  [NUM_INTS-1:0] int_en_q;
    reg  [NUM_INTS-1:0] int_flag_q;
    reg  [2:0]          wake_cause_q;
    reg  [10:0]         ost_cnt_q;
    reg  [1:0]          dummy_cnt_q;
    reg  [13:0]         lf_div_q;
    reg                 aw_done_q;
    reg                 w_done_q;
    reg  [5:0]          awaddr_q;
    reg  [31:0]         wdata_q;

    wire                lf_tick;
    wire                pending;
    wire                reset_wake;
    wire                wdt_run;
    wire                wdt_timeout;
    wire                wdt_clear;
    wire                sleep_go;
    wire                sleep_nop;
    wire                int_wake;
    wire                crystal;
    wire                wr_fire;
    wire [NUM_INTS-1:0] int_set;

    // Flags latched from sources; set wins over a software clear
    genvar g;
    generate
        for (g = 0; g < NUM_INTS; g = g + 1) begin : g_flag
            assign int_set[g] = int_src_i[g] & (state_q != ST_SLEEP | int_sleep_capable_i[g]);
        end
    endgenerate

    assign pending    = |(int_flag_q & int_en_q);
    assign sleep_go   = sleep_exec_i && state_q == ST_AWAKE && !pending;
    assign sleep_nop  = sleep_exec_i && state_q == ST_AWAKE && pending;
    assign int_wake   = state_q == ST_SLEEP && pending;
    assign reset_wake = por_i || (brownout_en_i && brownout_reset_i) ||
                        (master_clear_en_i && master_clear_pin_i);
    assign crystal    = ctrl_q[`CTRL_OSC_MSB:`CTRL_OSC_LSB] == `OSC_MODE_XT ||
                        ctrl_q[`CTRL_OSC_MSB:`CTRL_OSC_LSB] == `OSC_MODE_HS ||
                        ctrl_q[`CTRL_OSC_MSB:`CTRL_OSC_LSB] == `OSC_MODE_LP;

    // Watchdog mode: software bit only counts in the soft mode
    assign wdt_run = wdt_mode_i == `WDTE_ALWAYS ||
                     (wdt_mode_i == `WDTE_AWAKE && state_q != ST_SLEEP) ||
                     (wdt_mode_i == `WDTE_SOFT && wdt_ctrl_q[0]);
    // Held clear through the start-up wait so it cannot bite mid-restart
    assign wdt_clear = sleep_go || clrwdt_exec_i || state_q == ST_OST ||
                       (state_q == ST_SLEEP && state_d != ST_SLEEP);

    // Low-frequency tick that paces the watchdog, also counted in sleep
    assign lf_tick = lf_div_q == LF_LAST[13:0];

    wdt_counter #(
        .WIDTH(WDT_WIDTH)
    ) u_wdt (
        .mclk_i      (mclk_i),
        .reset_n_i   (reset_n_i),
        .tick_i      (lf_tick),
        .clear_i     (wdt_clear),
        .run_i       (wdt_run),
        .period_sel_i(wdt_ctrl_q[5:1]),
        .count_o     (),
        .timeout_o   (wdt_timeout)
    );

    // Only the CPU clock and a converter without its RC clock stop in sleep
    assign cpu_clk_en_o   = state_q != ST_SLEEP && state_q != ST_OST;
    assign lf_osc_en_o    = 1'b1;
    assign sec_osc_en_o   = 1'b1;
    assign adc_clk_en_o   = state_q != ST_SLEEP || ctrl_q[`CTRL_ADC_RC_BIT];
    assign sense_osc_en_o = 1'b1;

    // Sleep, optional start-up wait, following instruction, dummy cycles
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_AWAKE: begin
                if (sleep_go) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (int_wake || wdt_timeout) begin
                    state_d = crystal ? ST_OST : ST_NEXT;
                end
            end
            ST_OST: begin
                if (ost_cnt_q == OST_LAST[10:0]) begin
                    state_d = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (instr_done_i) begin
                    state_d = ctrl_q[`CTRL_GIE_BIT] && pending ? ST_DUMMY : ST_AWAKE;
                end
            end
            ST_DUMMY: begin
                if (dummy_cnt_q == DUMMY_LAST[1:0]) begin
                    state_d = ST_AWAKE;
                end
            end
            default: state_d = ST_AWAKE;
        endcase
    end

    always @(posedge mclk_i) begin
        if (!reset_n_i || reset_wake) begin
            state_q        <= ST_AWAKE;
            ost_cnt_q      <= 11'h000;
            dummy_cnt_q    <= 2'h0;
            lf_div_q       <= 14'h0000;
            device_reset_o <= !reset_n_i ? 1'b0 : 1'b1;
            prefetch_o     <= 1'b0;
            vector_o       <= 1'b0;
            vector_addr_o  <= 15'h0000;
            dummy_cycle_o  <= 1'b0;
            asleep_o       <= 1'b0;
            io_out_o       <= {NUM_IO{1'b0}};
            io_oe_o        <= {NUM_IO{1'b0}};
        end else begin
            state_q        <= state_d;
            device_reset_o <= 1'b0;
            lf_div_q       <= lf_tick ? 14'h0000 : lf_div_q + 14'h0001;
            ost_cnt_q      <= state_q == ST_OST ? ost_cnt_q + 11'h001 : 11'h000;
            dummy_cnt_q    <= state_q == ST_DUMMY ? dummy_cnt_q + 2'h1 : 2'h0;
            prefetch_o     <= sleep_go;
            dummy_cycle_o  <= state_d == ST_DUMMY;
            vector_o       <= state_q == ST_DUMMY && state_d == ST_AWAKE;
            vector_addr_o  <= `ISR_VECTOR;
            asleep_o       <= state_d == ST_SLEEP || state_d == ST_OST;
            // Pin drive is copied only while awake, which freezes it in sleep
            if (state_q == ST_AWAKE) begin
                io_out_o <= io_out_i;
                io_oe_o  <= io_oe_i;
            end
        end
    end

    // Register bus: one write and one read at a time, answer one cycle after both halves
    assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_done_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = (aw_done_q || s_axi_awvalid) && (w_done_q || s_axi_wvalid) &&
                           !s_axi_bvalid;

    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            aw_done_q    <= 1'b0;
            w_done_q     <= 1'b0;
            awaddr_q     <= 6'h00;
            wdata_q      <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_done_q    <= 1'b0;
                w_done_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_done_q ? awaddr_q : s_axi_awaddr)
                    `ADDR_CTRL, `ADDR_STATUS, `ADDR_WDT_CTRL, `ADDR_INT_ENABLE,
                    `ADDR_INT_FLAG, `ADDR_WAKE_CAUSE: s_axi_bresp <= `RESP_OKAY;
                    default:                          s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_CTRL:       s_axi_rdata <= {28'h0000000, ctrl_q};
                    `ADDR_STATUS:     s_axi_rdata <= {27'h0000000, to_flag_n_q, pd_flag_n_q,
                                                      3'h0};
                    `ADDR_WDT_CTRL:   s_axi_rdata <= {26'h0000000, wdt_ctrl_q};
                    `ADDR_INT_ENABLE: s_axi_rdata <= {{(32-NUM_INTS){1'b0}}, int_en_q};
                    `ADDR_INT_FLAG:   s_axi_rdata <= {{(32-NUM_INTS){1'b0}}, int_flag_q};
                    `ADDR_WAKE_CAUSE: s_axi_rdata <= {29'h00000000, wake_cause_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Register contents and status flags
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ctrl_q       <= 4'h0;
            wdt_ctrl_q   <= `WDT_CTRL_RESET;
            int_en_q     <= {NUM_INTS{1'b0}};
            int_flag_q   <= {NUM_INTS{1'b0}};
            pd_flag_n_q  <= 1'b1;
            to_flag_n_q  <= 1'b1;
            wake_cause_q <= 3'h0;
        end else begin
            if (wr_fire && (aw_done_q ? awaddr_q : s_axi_awaddr) == `ADDR_CTRL &&
                s_axi_wstrb[0]) begin
                ctrl_q <= (w_done_q ? wdata_q[3:0] : s_axi_wdata[3:0]);
            end
            if (wr_fire && (aw_done_q ? awaddr_q : s_axi_awaddr) == `ADDR_WDT_CTRL &&
                s_axi_wstrb[0]) begin
                wdt_ctrl_q <= (w_done_q ? wdata_q[5:0] : s_axi_wdata[5:0]);
            end
            if (wr_fire && (aw_done_q ? awaddr_q : s_axi_awaddr) == `ADDR_INT_ENABLE) begin
                int_en_q <= (w_done_q ? wdata_q[NUM_INTS-1:0] : s_axi_wdata[NUM_INTS-1:0]);
            end
            // Write one to clear; a source firing the same cycle keeps its flag
            if (wr_fire && (aw_done_q ? awaddr_q : s_axi_awaddr) == `ADDR_INT_FLAG) begin
                int_flag_q <= (int_flag_q & ~(w_done_q ? wdata_q[NUM_INTS-1:0] :
                               s_axi_wdata[NUM_INTS-1:0])) | int_set;
            end else begin
                int_flag_q <= int_flag_q | int_set;
            end
            if (sleep_go) begin
                pd_flag_n_q <= 1'b0;
                to_flag_n_q <= 1'b1;
            end else if (state_q == ST_SLEEP && wdt_timeout && !int_wake) begin
                to_flag_n_q <= 1'b0;
            end else if (clrwdt_exec_i) begin
                pd_flag_n_q <= 1'b1;
                to_flag_n_q <= 1'b1;
            end
            // Wake cause: 1 interrupt, 2 watchdog, 4 sleep taken as no-op
            if (state_q == ST_SLEEP && state_d != ST_SLEEP) begin
                wake_cause_q <= int_wake ? 3'h1 : 3'h2;
            end else if (sleep_nop) begin
                wake_cause_q <= 3'h4;
            end
        end
    end
endmodule // sleep_wakeup_controller

//--- logic/wdt_counter.v
// Watchdog counter with clear, enable and time-out compare
`timescale 1ns/10ps
module wdt_counter #(
    parameter WIDTH = 24
) (
    input  wire             mclk_i,
    input  wire             reset_n_i,
    input  wire             tick_i,
    input  wire             clear_i,
    input  wire             run_i,
    input  wire [4:0]       period_sel_i,
    output reg  [WIDTH-1:0] count_o,
    output reg              timeout_o
);
    wire [WIDTH-1:0] limit;
    assign limit = ({{(WIDTH-1){1'b0}}, 1'b1} << (period_sel_i + 5'h05)) - {{(WIDTH-1){1'b0}}, 1'b1};
    always @(posedge mclk_i) begin
        if (!reset_n_i || clear_i || !run_i) begin
            count_o   <= {WIDTH{1'b0}};
            timeout_o <= 1'b0;
        end else if (tick_i) begin
            if (count_o >= limit) begin
                count_o   <= {WIDTH{1'b0}};
                timeout_o <= 1'b1;
            end else begin
                count_o   <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
                timeout_o <= 1'b0;
            end
        end else begin
            timeout_o <= 1'b0;
        end
    end
endmodule // wdt_counter

//--- verif/core_model.sv
// Core-side partner: issues the sleep instruction and finishes the instruction after wake
`timescale 1ns/10ps
module core_model (
    input  wire       mclk_i,
    input  wire       sleep_req_i,
    input  wire [3:0] done_delay_i,
    input  wire       asleep_i,
    output logic      sleep_exec_o = 1'b0,
    output logic      instr_done_o = 1'b0
);
    logic       was_asleep_q = 1'b0;
    logic [4:0] wait_q = 5'h00;
    always @(posedge mclk_i) begin
        sleep_exec_o <= sleep_req_i;
        was_asleep_q <= asleep_i;
        // Software keeps a no-op after sleep, so running it on wake is harmless
        instr_done_o <= (wait_q == 5'h01);
        // The prefetched instruction may take a short or a long time to finish
        if (was_asleep_q && !asleep_i) begin
            wait_q <= {1'b0, done_delay_i} + 5'h01;
        end else if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
        end
    end
endmodule // core_model

//--- verif/sleep_wakeup_controller_bench.sv
// Register and sleep sequence tests for the sleep and wake-up controller
`timescale 1ns/10ps
`include "sleep_wakeup_defs.vh"
module sleep_wakeup_controller_bench;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, sleep_req = 1'b0, clrwdt_exec_i = 1'b0;
    logic        brownout_reset_i = 1'b0, master_clear_pin_i = 1'b0, master_clear_en_i = 1'b0;
    logic        por_i = 1'b0, brownout_en_i = 1'b0;
    logic [1:0]  wdt_mode_i = 2'h0, rs;
    logic [3:0]  done_delay = 4'h0;
    logic [15:0] int_src_i = 16'h0000;
    logic [7:0]  io_out_i = 8'hA5, io_oe_i = 8'h0F, nv, nd;
    logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [14:0] va;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         sleep_exec_i, instr_done_i, cpu_clk_en_o, lf_osc_en_o, sec_osc_en_o;
    wire         adc_clk_en_o, sense_osc_en_o, device_reset_o, prefetch_o, vector_o;
    wire         dummy_cycle_o, asleep_o;
    wire  [14:0] vector_addr_o;
    wire  [7:0]  io_out_o, io_oe_o;
    int          miscompares = 0, n_checks = 0, m, c;
    core_model core_u (.mclk_i, .sleep_req_i(sleep_req), .done_delay_i(done_delay),
        .asleep_i(asleep_o), .sleep_exec_o(sleep_exec_i), .instr_done_o(instr_done_i));
    // Short watchdog tick keeps a sleep time-out within a few hundred cycles
    sleep_wakeup_controller #(.LF_DIV(4)) dut_u (
        .mclk_i, .reset_n_i, .sleep_exec_i, .clrwdt_exec_i, .instr_done_i, .por_i,
        .brownout_reset_i, .brownout_en_i, .master_clear_pin_i, .master_clear_en_i,
        .wdt_mode_i, .int_src_i, .int_sleep_capable_i(16'hFFFF), .io_out_i, .io_oe_i,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cpu_clk_en_o, .lf_osc_en_o, .sec_osc_en_o,
        .adc_clk_en_o, .sense_osc_en_o, .device_reset_o, .prefetch_o, .vector_o,
        .vector_addr_o, .dummy_cycle_o, .asleep_o, .io_out_o, .io_oe_o);
    initial forever #2 mclk_i = ~mclk_i;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        stop_test();
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic axi(input logic wr, input logic [5:0] a, input logic [31:0] d);
        logic fin, aw_ok, w_ok, ar_ok;
        int n;
        fin = 1'b0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (n = 0; n < 64 && !fin; n++) begin
            // Values seen mid-cycle are what the next rising edge samples
            @(negedge mclk_i);
            aw_ok = s_axi_awready;
            w_ok = s_axi_wready;
            ar_ok = s_axi_arready;
            fin = wr ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge mclk_i);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (ar_ok) s_axi_arvalid <= 1'b0;
            if (fin) s_axi_bready <= 1'b0;
            if (fin) s_axi_rready <= 1'b0;
        end
        // Idle edge so the next call never drives a strobe twice in one step
        @(posedge mclk_i);
        if (!fin) hang();
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] msk,
                        input logic [31:0] exp);
        axi(1'b0, a, 32'h0);
        chk(nm, exp, rd & msk);
    endtask
    task automatic wait_sl(input logic lvl, input int lim, input logic must);
        for (c = 0; c < lim; c++) begin
            @(negedge mclk_i);
            if (asleep_o === lvl) break;
        end
        @(posedge mclk_i);
        if (must && c == lim) hang();
    endtask
    task automatic go_sleep(input logic must);
        sleep_req <= 1'b1;
        @(posedge mclk_i);
        sleep_req <= 1'b0;
        wait_sl(1'b1, 10, must);
    endtask
    task automatic pulse_int;
        int_src_i <= 16'h0001;
        @(posedge mclk_i);
        int_src_i <= 16'h0000;
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        rchk("status reset", `ADDR_STATUS, 32'h18, 32'h18);
        rchk("wdt ctrl reset", `ADDR_WDT_CTRL, 32'h3F, 32'(`WDT_CTRL_RESET));
        axi(1'b0, 6'h3C, 32'h0);
        chk("unmapped resp", 32'(`RESP_SLVERR), 32'(rs));
        axi(1'b1, 6'h3C, 32'h0);
        chk("unmapped wr resp", 32'(`RESP_SLVERR), 32'(rs));
        axi(1'b1, `ADDR_INT_ENABLE, 32'h0000_0001);
        $display("test register reset done");
        // Each oscillator mode once; global enable on in modes 2 and 3, RC conversion clock on in modes 1 and 3
        for (m = 0; m < 4; m++) begin
            done_delay <= 4'(m * 3);
            io_out_i <= 8'hA5;
            io_oe_i <= 8'h0F;
            axi(1'b1, `ADDR_INT_FLAG, 32'h0000_FFFF);
            axi(1'b1, `ADDR_CTRL, 32'(m * 4 + m % 2 * 2 + m / 2));
            go_sleep(1'b1);
            io_out_i <= 8'h5A;
            io_oe_i <= 8'hF0;
            rchk("status asleep", `ADDR_STATUS, 32'h18, 32'h10);
            chk("clock enables", 32'({1'b0, m[0], 3'b111}), 32'({cpu_clk_en_o, adc_clk_en_o,
                lf_osc_en_o, sec_osc_en_o, sense_osc_en_o}));
            chk("pins held", 32'h0FA5, 32'({io_oe_o, io_out_o}));
            pulse_int();
            wait_sl(1'b0, 1100, 1'b1);
            chk("wake delay", 32'h1, 32'(m ? (c >= 1023 && c <= 1032) : c < 8));
            nv = 8'h00;
            nd = 8'h00;
            va = 15'h0000;
            repeat (60) begin
                @(negedge mclk_i);
                nv = nv + 8'(vector_o);
                nd = nd + 8'(dummy_cycle_o);
                if (vector_o) va = vector_addr_o;
            end
            @(posedge mclk_i);
            chk("vector count", 32'(m / 2), 32'(nv));
            chk("dummy cycles", 32'(m / 2 * `DUMMY_CYCLES), 32'(nd));
            chk("vector addr", 32'(m / 2 * 4), 32'(va));
            chk("cpu clock awake", 32'h1, 32'(cpu_clk_en_o));
            rchk("status woke", `ADDR_STATUS, 32'h18, 32'h10);
            rchk("wake cause", `ADDR_WAKE_CAUSE, 32'h07, 32'h1);
            $display("test interrupt wake mode %0d done", m);
        end
        axi(1'b1, `ADDR_CTRL, 32'h0);
        clrwdt_exec_i <= 1'b1;
        @(posedge mclk_i);
        clrwdt_exec_i <= 1'b0;
        pulse_int();
        go_sleep(1'b0);
        chk("no-op sleep", 32'h0A, 32'(c));
        rchk("status no-op", `ADDR_STATUS, 32'h18, 32'h18);
        rchk("cause no-op", `ADDR_WAKE_CAUSE, 32'h07, 32'h4);
        $display("test pending interrupt done");
        axi(1'b1, `ADDR_INT_FLAG, 32'h0000_FFFF);
        wdt_mode_i <= `WDTE_AWAKE;
        // Power-on, then brownout, then master clear; disabled sources must not wake
        for (m = 0; m < 3; m++) begin
            go_sleep(1'b1);
            master_clear_pin_i <= 1'b1;
            brownout_reset_i <= 1'b1;
            int_src_i <= 16'h0002;
            wait_sl(1'b0, 400, 1'b0);
            chk("sleep held", 32'h190, 32'(c));
            {por_i, brownout_en_i, master_clear_en_i} <= 3'(4 >> m);
            wait_sl(1'b0, 10, 1'b1);
            chk("device reset", 32'h1, 32'(device_reset_o));
            {por_i, brownout_en_i, master_clear_en_i, master_clear_pin_i} <= 4'h0;
            brownout_reset_i <= 1'b0;
            int_src_i <= 16'h0000;
        end
        wdt_mode_i <= 2'h0;
        $display("test reset wake done");
        axi(1'b1, `ADDR_WDT_CTRL, 32'h0);
        wdt_mode_i <= `WDTE_ALWAYS;
        go_sleep(1'b1);
        wait_sl(1'b0, 1000, 1'b1);
        wdt_mode_i <= 2'h0;
        rchk("wdt cause", `ADDR_WAKE_CAUSE, 32'h07, 32'h2);
        rchk("wdt status", `ADDR_STATUS, 32'h18, 32'h00);
        $display("test watchdog wake done");
        stop_test();
    end
endmodule // sleep_wakeup_controller_bench

//--- verif/sleep_wakeup_controller_monitor.sv
// Port-level assertions for the sleep and wake-up controller
`timescale 1ns/10ps
module sleep_wakeup_controller_monitor #(
    parameter NUM_IO = 8
) (
    input wire              mclk_i,
    input wire              reset_n_i,
    input wire              sleep_exec_i,
    input wire              por_i,
    input wire              brownout_reset_i,
    input wire              brownout_en_i,
    input wire              master_clear_pin_i,
    input wire              master_clear_en_i,
    input wire              cpu_clk_en_o,
    input wire              lf_osc_en_o,
    input wire              sec_osc_en_o,
    input wire              sense_osc_en_o,
    input wire              device_reset_o,
    input wire              prefetch_o,
    input wire              vector_o,
    input wire [14:0]       vector_addr_o,
    input wire              dummy_cycle_o,
    input wire              asleep_o,
    input wire [NUM_IO-1:0] io_out_o,
    input wire [NUM_IO-1:0] io_oe_o
);
    // Disabled sources must not count, so the enables are folded in here
    wire rst_src = por_i || (brownout_reset_i && brownout_en_i)
                   || (master_clear_pin_i && master_clear_en_i);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    sleep_cause_a: assert property (
        $rose(asleep_o) |-> $past(sleep_exec_i) || $past(sleep_exec_i, 2))
        else $error("sleep entered without a sleep instruction");
    clk_gate_a: assert property (asleep_o |-> !cpu_clk_en_o)
        else $error("cpu clock running while asleep");
    osc_run_a: assert property (lf_osc_en_o && sec_osc_en_o && sense_osc_en_o)
        else $error("low-power oscillator stopped");
    prefetch_a: assert property ($rose(asleep_o) |-> prefetch_o ##1 !prefetch_o)
        else $error("no single prefetch pulse on sleep entry");
    io_hold_a: assert property (
        asleep_o && $past(asleep_o) |-> $stable(io_out_o) && $stable(io_oe_o))
        else $error("pin drive changed while asleep");
    reset_wake_a: assert property ($rose(rst_src) |=> device_reset_o)
        else $error("reset source gave no device reset");
    dummy_len_a: assert property (
        $rose(dummy_cycle_o) |-> dummy_cycle_o [*2] ##1 !dummy_cycle_o)
        else $error("dummy cycle count wrong");
    vector_addr_a: assert property (
        vector_o |-> vector_addr_o == 15'h0004 && $past(dummy_cycle_o))
        else $error("vector without dummy cycles or at wrong address");
    cover property ($rose(asleep_o));
    cover property (vector_o);
    cover property (device_reset_o);
endmodule // sleep_wakeup_controller_monitor
bind sleep_wakeup_controller sleep_wakeup_controller_monitor #(.NUM_IO(NUM_IO)) mon_u (
    .mclk_i, .reset_n_i, .sleep_exec_i, .por_i, .brownout_reset_i, .brownout_en_i,
    .master_clear_pin_i, .master_clear_en_i, .cpu_clk_en_o, .lf_osc_en_o, .sec_osc_en_o,
    .sense_osc_en_o, .device_reset_o, .prefetch_o, .vector_o, .vector_addr_o,
    .dummy_cycle_o, .asleep_o, .io_out_o, .io_oe_o);
